// *** include/rnq_defines.vh ***
// constants for the reservation notice queue
`ifndef RNQ_DEFINES_VH
`define RNQ_DEFINES_VH
`define RNQ_DEPTH 8
`define RNQ_PTR_W 3
`define RNQ_CNT_W 4
`define RNQ_CNT_WIDTH 64
`define RNQ_NSID_W 32
`define RNQ_TYPE_W 8
`define RNQ_TYPE_EMPTY 8'h00
`define RNQ_TYPE_REG_PREEMPT 8'h01
`define RNQ_TYPE_RSV_RELEASE 8'h02
`define RNQ_TYPE_RSV_PREEMPT 8'h03
`define RNQ_AVAIL_MAX 8'hFF
`define RNQ_COUNT_MAX 64'hFFFFFFFFFFFFFFFF
`define RNQ_COUNT_RESET 64'h0000000000000000
`define RNQ_COUNT_WRAP 64'h0000000000000001
`define RNQ_ENTRY_W 104
`define RNQ_PAGE_BYTES 64
`define RNQ_PAGE_W 512
`endif

// *** hdl/rnq_entry_store.v ***
// entry storage for the reservation notice queue
`timescale 1ns/1ps
`include "rnq_defines.vh"
module rnq_entry_store (
    input wire clk_sys,
    input wire rstn,
    input wire wr_en,
    input wire [`RNQ_PTR_W-1:0] wr_idx,
    input wire [`RNQ_ENTRY_W-1:0] wr_data,
    input wire upd_en,
    input wire [`RNQ_PTR_W-1:0] upd_idx,
    input wire [`RNQ_CNT_WIDTH-1:0] upd_count,
    input wire [`RNQ_PTR_W-1:0] rd_idx,
    output wire [`RNQ_ENTRY_W-1:0] rd_data
);
    reg [`RNQ_ENTRY_W-1:0] mem_reg [0:`RNQ_DEPTH-1];
    genvar gi;
    generate
        for (gi = 0; gi < `RNQ_DEPTH; gi = gi + 1) begin : g_ent
            always @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    mem_reg[gi] <= {`RNQ_ENTRY_W{1'b0}};
                end else if (wr_en && wr_idx == gi) begin
                    mem_reg[gi] <= wr_data;
                end else if (upd_en && upd_idx == gi) begin
                    // lost notice: tail keeps type and namespace, count moves on
                    mem_reg[gi][`RNQ_CNT_WIDTH-1:0] <= upd_count;
                end
            end
        end
    endgenerate
    assign rd_data = mem_reg[rd_idx];
endmodule // rnq_entry_store

// *** hdl/rnq_queue.v ***
// reservation notice queue: event counter, queue and page builder
//
// Function
// - an unmasked notice on any attached namespace appends a new entry at tail
// - a page read returns the oldest queued entry, lowest count with wrap
// - the returned entry is removed so the next read gets the following one
// - a read of an empty queue returns an all-zero page
// - a notice arriving while the queue is full is dropped, unless a page read pops an entry in the same cycle
// - a dropped notice moves the tail entry count to the dropped count
// - each entry carries a 64-bit incrementing count in bytes 7:0
// - the event counter is zero after controller reset
// - the counter steps for every unmasked notice event, stored or not
// - at its maximum the counter wraps to one, never to zero
// - byte 8 type: 0 empty, 1 registration preempted, 2 released
// - one queue serves the whole controller, not one per namespace
// - byte 9 gives remaining unread entries, saturating at 255
// - bytes 15:12 hold the namespace id of the notice
`timescale 1ns/1ps
`include "rnq_defines.vh"
module rnq_queue (
    input wire clk_sys,
    input wire rstn,
    input wire ctrl_reset,
    input wire evt_valid,
    input wire evt_masked,
    input wire [`RNQ_TYPE_W-1:0] evt_type,
    input wire [`RNQ_NSID_W-1:0] evt_nsid,
    input wire rd_req,
    output wire rd_ready,
    output reg rd_valid,
    output reg [`RNQ_PAGE_W-1:0] rd_page,
    output reg [`RNQ_CNT_W-1:0] fill_level,
    output reg drop_pulse,
    output reg [`RNQ_CNT_WIDTH-1:0] event_count
);
    localparam [`RNQ_CNT_W-1:0] DEPTH_C = `RNQ_DEPTH;
    localparam [`RNQ_PTR_W-1:0] PTR_ONE = 1;
    localparam [`RNQ_CNT_W-1:0] CNT_ONE = 1;

    reg [`RNQ_CNT_WIDTH-1:0] count_reg;
    reg [`RNQ_CNT_WIDTH-1:0] count_next;
    reg [`RNQ_PTR_W-1:0] head_reg;
    reg [`RNQ_PTR_W-1:0] tail_reg;
    reg [`RNQ_CNT_W-1:0] used_reg;
    reg [`RNQ_CNT_W-1:0] used_next;
    wire [`RNQ_ENTRY_W-1:0] head_entry;
    wire evt_take;
    wire q_empty;
    wire q_full;
    wire pop;
    wire push;
    wire drop;
    wire [`RNQ_PTR_W-1:0] last_idx;
    reg [`RNQ_CNT_W-1:0] remain;
    reg [`RNQ_PAGE_W-1:0] page;

    // masked notices do not count either: they never cause a notification
    assign evt_take = evt_valid && !evt_masked;
    assign q_empty = (used_reg == {`RNQ_CNT_W{1'b0}});
    assign q_full = (used_reg == DEPTH_C);
    assign rd_ready = 1'b1;
    assign pop = rd_req && !q_empty;
    // a pop in the same cycle frees a slot, so a full queue still accepts
    assign push = evt_take && (!q_full || pop);
    assign drop = evt_take && q_full && !pop;
    assign last_idx = tail_reg - PTR_ONE;

    always @* begin
        count_next = count_reg + 64'h0000000000000001;
        if (count_reg == `RNQ_COUNT_MAX) begin
            count_next = `RNQ_COUNT_WRAP;
        end
    end

    always @* begin
        used_next = used_reg;
        if (push && !pop) begin
            used_next = used_reg + CNT_ONE;
        end else if (pop && !push) begin
            used_next = used_reg - CNT_ONE;
        end
    end

    rnq_entry_store u_store (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wr_en(push && !ctrl_reset),
        .wr_idx(tail_reg),
        .wr_data({evt_nsid, evt_type, count_next}),
        .upd_en(drop && !ctrl_reset),
        .upd_idx(last_idx),
        .upd_count(count_next),
        .rd_idx(head_reg),
        .rd_data(head_entry)
    );

    always @* begin
        remain = used_reg - CNT_ONE;
        page = {`RNQ_PAGE_W{1'b0}};
        if (!q_empty) begin
            page[63:0] = head_entry[`RNQ_CNT_WIDTH-1:0];
            page[71:64] = head_entry[71:64];
            // depth is below 255, so saturation never triggers here
            page[79:72] = (remain > 4'hF) ? `RNQ_AVAIL_MAX : {4'h0, remain};
            page[127:96] = head_entry[103:72];
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count_reg <= `RNQ_COUNT_RESET;
            head_reg <= {`RNQ_PTR_W{1'b0}};
            tail_reg <= {`RNQ_PTR_W{1'b0}};
            used_reg <= {`RNQ_CNT_W{1'b0}};
            rd_valid <= 1'b0;
            rd_page <= {`RNQ_PAGE_W{1'b0}};
            fill_level <= {`RNQ_CNT_W{1'b0}};
            drop_pulse <= 1'b0;
            event_count <= `RNQ_COUNT_RESET;
        end else if (ctrl_reset) begin
            count_reg <= `RNQ_COUNT_RESET;
            head_reg <= {`RNQ_PTR_W{1'b0}};
            tail_reg <= {`RNQ_PTR_W{1'b0}};
            used_reg <= {`RNQ_CNT_W{1'b0}};
            rd_valid <= 1'b0;
            rd_page <= {`RNQ_PAGE_W{1'b0}};
            fill_level <= {`RNQ_CNT_W{1'b0}};
            drop_pulse <= 1'b0;
            event_count <= `RNQ_COUNT_RESET;
        end else begin
            if (evt_take) begin
                count_reg <= count_next;
                event_count <= count_next;
            end
            if (push) begin
                tail_reg <= tail_reg + PTR_ONE;
            end
            if (pop) begin
                head_reg <= head_reg + PTR_ONE;
            end
            used_reg <= used_next;
            fill_level <= used_next;
            drop_pulse <= drop;
            rd_valid <= rd_req;
            if (rd_req) begin
                rd_page <= page;
            end
        end
    end
endmodule // rnq_queue

// *** verification/rnq_monitor.sv ***
// port checker for the notice queue
`timescale 1ns/1ps
module rnq_monitor (
    input logic clk_sys,
    input logic rstn,
    input logic ctrl_reset,
    input logic evt_valid,
    input logic evt_masked,
    input logic rd_req,
    input logic rd_valid,
    input logic [511:0] rd_page,
    input logic [3:0] fill_level,
    input logic drop_pulse,
    input logic [63:0] event_count
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_evt; evt_valid && !evt_masked && !ctrl_reset; endsequence
    sequence s_rd; rd_req && !ctrl_reset; endsequence
    AST_RD: assert property (s_rd |=> rd_valid && rd_page[511:128] == 0)
        else $error("bad read answer");
    AST_EMPTY: assert property (s_rd ##0 fill_level == 0 |=> rd_page == 0)
        else $error("empty page not zero");
    AST_CNT: assert property (s_evt |=> event_count ==
        ($past(event_count) == '1 ? 64'h1 : $past(event_count) + 64'h1))
        else $error("bad count step");
    AST_HOLD: assert property ((!evt_valid || evt_masked) && !ctrl_reset |=>
        $stable(event_count)) else $error("count moved");
    AST_CLR: assert property (ctrl_reset |=> event_count == 0 && fill_level == 0)
        else $error("reset not cleared");
    AST_DROP: assert property (s_evt ##0 (fill_level == 8 && !rd_req) |=>
        drop_pulse && fill_level == 8) else $error("no drop");
    AST_PUSH: assert property (s_evt ##0 (fill_level < 8 && !rd_req) |=>
        fill_level == $past(fill_level) + 1) else $error("no push");
    AST_POP: assert property (s_rd ##0 (fill_level != 0 && !evt_valid) |=>
        fill_level == $past(fill_level) - 1 && rd_page[79:72] == fill_level)
        else $error("bad pop");
endmodule // rnq_monitor
bind rnq_queue rnq_monitor mon_u (.clk_sys, .rstn, .ctrl_reset, .evt_valid, .evt_masked,
    .rd_req, .rd_valid, .rd_page, .fill_level, .drop_pulse, .event_count);

// *** verification/rnq_host_model.sv ***
// host model issuing page reads
`timescale 1ns/1ps
module rnq_host_model (
    input logic clk_sys,
    output logic rd_req
);
    initial rd_req = 1'b0;
    // one-cycle request; page is settled two falling edges later
    task automatic read_page;
        @(negedge clk_sys);
        rd_req = 1'b1;
        @(negedge clk_sys);
        rd_req = 1'b0;
        @(negedge clk_sys);
    endtask
endmodule // rnq_host_model

// *** verification/rnq_queue_tb_top.sv ***
// bench for the notice queue
`timescale 1ns/1ps
module rnq_queue_tb_top;
    logic clk_sys = 0, rstn = 0, ctrl_reset = 0, evt_valid = 0, evt_masked = 0;
    logic rd_req, rd_valid, drop_pulse;
    logic [7:0] evt_type = '0;
    logic [31:0] evt_nsid = '0;
    logic [511:0] rd_page;
    logic [3:0] fill_level;
    logic [63:0] event_count;
    int failures = 0, checks = 0;
    // rows: type, namespace, expected count
    logic [103:0] rows [3] = '{{8'h01, 32'h5, 64'h1}, {8'h02, 32'h9, 64'h2},
        {8'h03, 32'h5, 64'h3}};
    rnq_queue dut_u (.clk_sys, .rstn, .ctrl_reset, .evt_valid, .evt_masked, .evt_type, .evt_nsid,
        .rd_req, .rd_ready(), .rd_valid, .rd_page, .fill_level, .drop_pulse, .event_count);
    rnq_host_model host_u (.clk_sys, .rd_req);
    task automatic chk(string s, logic [63:0] e, logic [63:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s %h %h", s, e, g);
        end
    endtask
    task automatic evt(logic [7:0] t, logic [31:0] n);
        @(negedge clk_sys);
        evt_valid = 1;
        evt_type = t;
        evt_nsid = n;
        @(negedge clk_sys);
        evt_valid = 0;
    endtask
    task automatic page(logic [63:0] c, logic [7:0] t, r, logic [31:0] n);
        host_u.read_page();
        chk("count", c, rd_page[63:0]);
        chk("type", t, rd_page[71:64]);
        chk("left", r, rd_page[79:72]);
        chk("nsid", n, rd_page[127:96]);
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial forever #2 clk_sys = ~clk_sys;
    initial begin
        #9000;
        failures++;
        stop_test();
    end
    initial begin
        repeat (3) @(negedge clk_sys);
        rstn = 1;
        foreach (rows[i]) evt(rows[i][103:96], rows[i][95:64]);
        foreach (rows[i]) page(rows[i][63:0], rows[i][103:96], 2 - i, rows[i][95:64]);
        page(0, 0, 0, 0);
        evt_masked = 1;
        evt(1, 1);
        evt_masked = 0;
        chk("masked", 3, event_count);
        repeat (10) evt(2, 7);
        chk("full", 8, fill_level);
        for (int k = 0; k < 7; k++) page(4 + k, 2, 7 - k, 7);
        page(13, 2, 0, 7);
        evt(1, 1);
        @(negedge clk_sys);
        ctrl_reset = 1;
        @(negedge clk_sys);
        ctrl_reset = 0;
        chk("cleared", 0, event_count);
        page(0, 0, 0, 0);
        evt(2, 3);
        chk("restart", 1, event_count);
        stop_test();
    end
endmodule // rnq_queue_tb_top
